// ### design/ssp_defs.vh
`ifndef SSP_DEFS_VH
`define SSP_DEFS_VH

// ---------------------------------------------------------------------
// register indices on the plain register port
// ---------------------------------------------------------------------
`define SSP_ADR_WORD0      5'h00
`define SSP_ADR_DWELL0     5'h08
`define SSP_ADR_REF_SEL    5'h10
`define SSP_ADR_OUT_SEL    5'h11
`define SSP_ADR_IN_SEL_LO  5'h12
`define SSP_ADR_IN_SEL_HI  5'h13
`define SSP_ADR_STATUS     5'h14

// ---------------------------------------------------------------------
// reset values and the dwell limit
// ---------------------------------------------------------------------
`define SSP_WORD_RST       16'h00F1
`define SSP_DWELL_RST      16'h012C
`define SSP_DWELL_MAX      16'h270F
`define SSP_SEL_RST        16'h0000

// ---------------------------------------------------------------------
// function codes
// ---------------------------------------------------------------------
`define SSP_MODE_SEQ       4'h6
`define SSP_OUT_FN_SEQ     5'h0F
`define SSP_IN_FN_A        5'h17
`define SSP_IN_FN_B        5'h18
`define SSP_CODE_NEVER     4'hF
`define SSP_DEST_NSTOP     4'h8
`define SSP_DEST_CSTOP     4'h9
`define SSP_DEST_FAULT     4'hA
`define SSP_TOP_GROUP2     4'h6
`define SSP_TOP_MAX        4'hB

// ---------------------------------------------------------------------
// field positions in a step word
// ---------------------------------------------------------------------
`define SSP_DIG_ADV        3:0
`define SSP_DIG_JMP        7:4
`define SSP_DIG_DST        11:8
`define SSP_DIG_TOP        15:12

// ---------------------------------------------------------------------
// timing
// ---------------------------------------------------------------------
`define SSP_TICK_MS        100
`define SSP_CLK_PERIOD_NS  5

`endif

// ### design/ssp_sequencer.v
// Design decisions made here: the register offsets and the strobed register port.
`timescale 1ns/1ps
`include "ssp_defs.vh"

module ssp_sequencer #(
  parameter TICK_CYCLES = (`SSP_TICK_MS * 1000000) / `SSP_CLK_PERIOD_NS
) (
  input  wire        mclk,
  input  wire        resetn,
  input  wire [4:0]  reg_addr,
  input  wire [15:0] reg_wdata,
  input  wire        reg_wr,
  input  wire        reg_rd,
  output reg  [15:0] reg_rdata,
  input  wire        run_cmd,
  input  wire        stop_req,
  input  wire [3:0]  din,
  output reg  [2:0]  preset_index,
  output reg         seq_active,
  output reg         ramp_sel2,
  output reg         dir_fwd,
  output reg         dir_rev,
  output reg         seq_aux_output,
  output wire        relay_out,
  output wire        opto_a_out,
  output wire        opto_b_out,
  output reg         normal_stop_req,
  output reg         coast_stop_req,
  output reg         sequence_end_fault
);

  // -------------------------------------------------------------------
  // local constants
  // -------------------------------------------------------------------
  localparam ST_IDLE = 2'b00;
  localparam ST_RUN  = 2'b01;
  localparam ST_END  = 2'b10;

  localparam [31:0] TICK_LAST = TICK_CYCLES - 1;

  // -------------------------------------------------------------------
  // condition evaluation shared by advance and jump digits
  // -------------------------------------------------------------------
  function cond_met;
    input [3:0] code;
    input       dwell_done;
    input       in_a;
    input       in_b;
    begin
      case (code)
        4'h0: cond_met = 1'b1;
        4'h1: cond_met = dwell_done;
        4'h2: cond_met = in_a;
        4'h3: cond_met = in_b;
        4'h4: cond_met = ~in_a;
        4'h5: cond_met = ~in_b;
        4'h6: cond_met = in_a | in_b;
        4'h7: cond_met = in_a & in_b;
        4'h8: cond_met = ~in_a & ~in_b;
        4'h9: cond_met = in_a & ~in_b;
        4'hA: cond_met = in_b & ~in_a;
        4'hB: cond_met = dwell_done & in_a;
        4'hC: cond_met = dwell_done & in_b;
        4'hD: cond_met = dwell_done & ~in_a;
        4'hE: cond_met = dwell_done & ~in_b;
        default: cond_met = 1'b0;
      endcase
    end
  endfunction

  // -------------------------------------------------------------------
  // register file
  // -------------------------------------------------------------------
  reg [15:0] step_words_ff [0:7];
  reg [15:0] step_dwell_times_ff [0:7];
  reg [3:0]  speed_ref_source_sel_ff;
  reg [14:0] out_sel_ff;      // relay, opto a, opto b, 5 bits each
  reg [19:0] input_terminal_function_sel_ff;

  reg [1:0]  state_ff;
  reg [2:0]  step_ff;
  reg [15:0] dwell_ff;
  reg [31:0] tick_cnt_ff;
  reg        run_prev_ff;

  integer i;

  // software writes; dwell clipped at its top so the timer compare holds
  always @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      for (i = 0; i < 8; i = i + 1) begin
        step_words_ff[i]       <= `SSP_WORD_RST;
        step_dwell_times_ff[i] <= `SSP_DWELL_RST;
      end
      speed_ref_source_sel_ff        <= 4'h0;
      out_sel_ff                     <= 15'h0000;
      input_terminal_function_sel_ff <= 20'h00000;
    end else if (reg_wr) begin
      if (reg_addr[4:3] == 2'b00) begin
        step_words_ff[reg_addr[2:0]] <= reg_wdata;
      end else if (reg_addr[4:3] == 2'b01) begin
        if (reg_wdata > `SSP_DWELL_MAX) begin
          step_dwell_times_ff[reg_addr[2:0]] <= `SSP_DWELL_MAX;
        end else begin
          step_dwell_times_ff[reg_addr[2:0]] <= reg_wdata;
        end
      end else if (reg_addr == `SSP_ADR_REF_SEL) begin
        speed_ref_source_sel_ff <= reg_wdata[3:0];
      end else if (reg_addr == `SSP_ADR_OUT_SEL) begin
        out_sel_ff <= reg_wdata[14:0];
      end else if (reg_addr == `SSP_ADR_IN_SEL_LO) begin
        input_terminal_function_sel_ff[9:0] <= reg_wdata[9:0];
      end else if (reg_addr == `SSP_ADR_IN_SEL_HI) begin
        input_terminal_function_sel_ff[19:10] <= reg_wdata[9:0];
      end
    end
  end

  // read data registered, valid only in the cycle after the strobe
  reg [15:0] nxt_rdata;
  always @* begin
    nxt_rdata = 16'h0000;
    if (reg_addr[4:3] == 2'b00) begin
      nxt_rdata = step_words_ff[reg_addr[2:0]];
    end else if (reg_addr[4:3] == 2'b01) begin
      nxt_rdata = step_dwell_times_ff[reg_addr[2:0]];
    end else begin
      case (reg_addr)
        `SSP_ADR_REF_SEL:   nxt_rdata = {12'h000, speed_ref_source_sel_ff};
        `SSP_ADR_OUT_SEL:   nxt_rdata = {1'b0, out_sel_ff};
        `SSP_ADR_IN_SEL_LO:
          nxt_rdata = {6'h00, input_terminal_function_sel_ff[9:0]};
        `SSP_ADR_IN_SEL_HI:
          nxt_rdata = {6'h00, input_terminal_function_sel_ff[19:10]};
        `SSP_ADR_STATUS:    nxt_rdata = {11'h000, state_ff, step_ff};
        default:            nxt_rdata = 16'h0000;
      endcase
    end
  end

  always @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      reg_rdata <= 16'h0000;
    end else if (reg_rd) begin
      reg_rdata <= nxt_rdata;
    end else begin
      reg_rdata <= 16'h0000;
    end
  end

  // -------------------------------------------------------------------
  // logic inputs from terminals
  // -------------------------------------------------------------------
  reg seq_input_a;
  reg seq_input_b;
  integer k;
  // several terminals on the same function are ORed together
  always @* begin
    seq_input_a = 1'b0;
    seq_input_b = 1'b0;
    for (k = 0; k < 4; k = k + 1) begin
      if (input_terminal_function_sel_ff[k*5 +: 5] == `SSP_IN_FN_A)
        seq_input_a = seq_input_a | din[k];
      if (input_terminal_function_sel_ff[k*5 +: 5] == `SSP_IN_FN_B)
        seq_input_b = seq_input_b | din[k];
    end
  end

  // -------------------------------------------------------------------
  // step decision
  // -------------------------------------------------------------------
  wire [15:0] cur_word   = step_words_ff[step_ff];
  wire [3:0]  adv_code   = cur_word[`SSP_DIG_ADV];
  wire [3:0]  jmp_code   = cur_word[`SSP_DIG_JMP];
  wire [3:0]  dst_code   = cur_word[`SSP_DIG_DST];
  wire [3:0]  top_code   = cur_word[`SSP_DIG_TOP];
  wire        dwell_done = (dwell_ff >= step_dwell_times_ff[step_ff]);
  wire        seq_mode   = (speed_ref_source_sel_ff == `SSP_MODE_SEQ);
  wire        start_edge = run_cmd & ~run_prev_ff;
  wire        tick       = (tick_cnt_ff == TICK_LAST);

  wire jump_hit = (jmp_code != `SSP_CODE_NEVER) &
                  cond_met(jmp_code, dwell_done, seq_input_a, seq_input_b);
  wire adv_hit  = cond_met(adv_code, dwell_done, seq_input_a, seq_input_b);

  reg [1:0] nxt_state;
  reg [2:0] nxt_step;
  reg       step_enter;
  reg       nxt_nstop;
  reg       nxt_cstop;
  reg       nxt_fault;

  // jump is tested before advance; a jump to the same step restarts dwell
  always @* begin
    nxt_state  = state_ff;
    nxt_step   = step_ff;
    step_enter = 1'b0;
    nxt_nstop  = normal_stop_req;
    nxt_cstop  = coast_stop_req;
    nxt_fault  = sequence_end_fault;
    case (state_ff)
      ST_IDLE: begin
        nxt_nstop = 1'b0;
        nxt_cstop = 1'b0;
        nxt_fault = 1'b0;
        if (start_edge && seq_mode && !stop_req) begin
          nxt_state  = ST_RUN;
          nxt_step   = 3'd0;
          step_enter = 1'b1;
        end
      end
      ST_RUN: begin
        if (!run_cmd || stop_req || !seq_mode) begin
          nxt_state = ST_IDLE;
        end else if (jump_hit) begin
          if (dst_code[3] == 1'b0) begin
            nxt_step   = dst_code[2:0];
            step_enter = 1'b1;
          end else if (dst_code == `SSP_DEST_NSTOP) begin
            nxt_state = ST_END;
            nxt_nstop = 1'b1;
          end else if (dst_code == `SSP_DEST_CSTOP) begin
            nxt_state = ST_END;
            nxt_cstop = 1'b1;
          end else if (dst_code == `SSP_DEST_FAULT) begin
            nxt_state = ST_END;
            nxt_fault = 1'b1;
          end
        end else if (adv_hit) begin
          nxt_step   = step_ff + 3'd1;
          step_enter = 1'b1;
        end
      end
      ST_END: begin
        // requests hold until the run command is dropped or a stop is requested
        if (!run_cmd || stop_req) begin
          nxt_state = ST_IDLE;
        end
      end
      default: begin
        nxt_state = ST_IDLE;
      end
    endcase
  end

  // -------------------------------------------------------------------
  // state, step and dwell timer
  // -------------------------------------------------------------------
  always @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      state_ff           <= ST_IDLE;
      step_ff            <= 3'd0;
      run_prev_ff        <= 1'b0;
      normal_stop_req    <= 1'b0;
      coast_stop_req     <= 1'b0;
      sequence_end_fault <= 1'b0;
    end else begin
      state_ff           <= nxt_state;
      step_ff            <= nxt_step;
      run_prev_ff        <= run_cmd;
      normal_stop_req    <= nxt_nstop;
      coast_stop_req     <= nxt_cstop;
      sequence_end_fault <= nxt_fault;
    end
  end

  // tick prescaler restarts with the step so every dwell is whole tenths
  always @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      tick_cnt_ff <= 32'd0;
      dwell_ff    <= 16'h0000;
    end else if (step_enter || state_ff != ST_RUN) begin
      tick_cnt_ff <= 32'd0;
      dwell_ff    <= 16'h0000;
    end else if (tick) begin
      tick_cnt_ff <= 32'd0;
      if (dwell_ff != `SSP_DWELL_MAX)
        dwell_ff <= dwell_ff + 16'h0001;
    end else begin
      tick_cnt_ff <= tick_cnt_ff + 32'd1;
    end
  end

  // -------------------------------------------------------------------
  // step outputs to the speed control
  // -------------------------------------------------------------------
  wire       top_ok  = (top_code <= `SSP_TOP_MAX);
  wire       grp2    = (top_code >= `SSP_TOP_GROUP2);
  wire [3:0] in_grp  = grp2 ? (top_code - `SSP_TOP_GROUP2) : top_code;
  wire       run_now = (state_ff == ST_RUN);

  // registered so the drive never sees a half-decoded digit
  always @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      preset_index   <= 3'd0;
      seq_active     <= 1'b0;
      ramp_sel2      <= 1'b0;
      dir_fwd        <= 1'b0;
      dir_rev        <= 1'b0;
      seq_aux_output <= 1'b0;
    end else begin
      preset_index   <= step_ff;
      seq_active     <= run_now;
      ramp_sel2      <= run_now & top_ok & grp2;
      seq_aux_output <= run_now & top_ok & (in_grp >= 4'd3);
      dir_fwd        <= run_now & top_ok &
                        (in_grp == 4'd0 || in_grp == 4'd3);
      dir_rev        <= run_now & top_ok &
                        (in_grp == 4'd1 || in_grp == 4'd4);
    end
  end

  // one shared aux state; any output on the sequence function follows it
  assign relay_out  = (out_sel_ff[4:0]   == `SSP_OUT_FN_SEQ) &
                      seq_aux_output;
  assign opto_a_out = (out_sel_ff[9:5]   == `SSP_OUT_FN_SEQ) &
                      seq_aux_output;
  assign opto_b_out = (out_sel_ff[14:10] == `SSP_OUT_FN_SEQ) &
                      seq_aux_output;

endmodule // ssp_sequencer

// ### test/ssp_sequencer_chk.sv
`timescale 1ns/1ps
module ssp_chk (
  input wire        mclk,
  input wire        resetn,
  input wire        reg_rd,
  input wire [15:0] reg_rdata,
  input wire        run_cmd,
  input wire        stop_req,
  input wire [2:0]  preset_index,
  input wire        seq_active,
  input wire        dir_fwd,
  input wire        dir_rev,
  input wire        seq_aux_output,
  input wire        relay_out,
  input wire        opto_a_out,
  input wire        opto_b_out,
  input wire        normal_stop_req,
  input wire        coast_stop_req,
  input wire        sequence_end_fault
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!resetn);
  // ---------------------------------------------------------------
  // sequences
  // ---------------------------------------------------------------
  sequence s_end_req;
    $rose(normal_stop_req || coast_stop_req || sequence_end_fault);
  endsequence
  sequence s_gone;
    !seq_active && !normal_stop_req && !coast_stop_req &&
    !sequence_end_fault;
  endsequence
  // read data only in the slot after a read strobe
  a_rdata_idle: assert property (
    !$past(reg_rd) |-> reg_rdata == 16'h0000)
    else $error("read data outside read slot");
  a_start_step0: assert property (
    $rose(seq_active) |-> preset_index == 3'h0)
    else $error("sequence did not start at step 0");
  a_end_halts: assert property (s_end_req |=> !seq_active [*2])
    else $error("sequence kept running after end");
  a_end_onehot: assert property (
    $onehot0({normal_stop_req, coast_stop_req, sequence_end_fault}))
    else $error("more than one end request");
  a_dir_excl: assert property (!(dir_fwd && dir_rev))
    else $error("forward and reverse together");
  a_aux_shared: assert property (
    (relay_out || opto_a_out || opto_b_out) |-> seq_aux_output)
    else $error("output on without shared aux state");
  // a stop request clears the run two edges later at most
  a_stop_idle: assert property (stop_req |-> ##2 s_gone)
    else $error("stop request did not idle");
  a_run_drop: assert property (!run_cmd |-> ##2 !seq_active)
    else $error("run removal did not idle");
endmodule // ssp_chk

bind ssp_sequencer ssp_chk u_chk (
  .mclk(mclk), .resetn(resetn), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
  .run_cmd(run_cmd), .stop_req(stop_req), .preset_index(preset_index),
  .seq_active(seq_active), .dir_fwd(dir_fwd), .dir_rev(dir_rev),
  .seq_aux_output(seq_aux_output), .relay_out(relay_out),
  .opto_a_out(opto_a_out), .opto_b_out(opto_b_out),
  .normal_stop_req(normal_stop_req), .coast_stop_req(coast_stop_req),
  .sequence_end_fault(sequence_end_fault));

// ### test/ssp_drive_model.sv
`timescale 1ns/1ps
// drive speed control: answers an end request by asserting stop after a
// delay, so the request stays visible for a few cycles only
module ssp_drive_model #(
  parameter ACK_DLY = 6
) (
  input  wire mclk,
  input  wire resetn,
  input  wire user_stop,
  input  wire end_req,
  output wire stop_req
);
  reg [3:0] wait_ff;
  reg       stop_ff;
  assign stop_req = stop_ff;
  // count how long an end request stands, then stop the drive
  always @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      wait_ff <= 4'h0;
      stop_ff <= 1'b0;
    end else begin
      wait_ff <= end_req ? wait_ff + 4'h1 : 4'h0;
      stop_ff <= user_stop || (wait_ff == ACK_DLY);
    end
  end
endmodule // ssp_drive_model

// ### test/ssp_sequencer_tb.sv
`timescale 1ns/1ps
module ssp_sequencer_tb;
  reg         mclk = 1'b0;
  reg         resetn = 1'b0;
  reg         reg_wr = 1'b0;
  reg         reg_rd = 1'b0;
  reg         run_cmd = 1'b0;
  reg         user_stop = 1'b0;
  reg [4:0]   reg_addr = 5'h00;
  reg [15:0]  reg_wdata = 16'h0000;
  reg [3:0]   din = 4'h0;
  reg [15:0]  d;
  reg [7:0]   r;
  reg         aux_e;
  integer     bad_count = 0;
  integer     tests_run = 0;
  integer     i;
  integer     n;
  wire [15:0] reg_rdata;
  wire [2:0]  preset_index;
  wire        seq_active, ramp_sel2, dir_fwd, dir_rev, seq_aux_output;
  wire        relay_out, opto_a_out, opto_b_out, stop_req;
  wire        normal_stop_req, coast_stop_req, sequence_end_fault;
  wire [6:0]  obs = {seq_active, normal_stop_req, coast_stop_req,
                     sequence_end_fault, preset_index};
  // code, in a, in b, advance expected, timed
  reg [175:0] rowv = {8'h02, 8'h13, 8'h2A, 8'h24, 8'h36, 8'h42, 8'h48,
    8'h5A, 8'h66, 8'h78, 8'h7E, 8'h82, 8'h88, 8'h9A, 8'h9C, 8'hA6, 8'hBB,
    8'hC7, 8'hD7, 8'hEB, 8'hB0, 8'hFC};
  reg [39:0]  jv = {8'h25, 8'h28, 8'h29, 8'h2A, 8'hF8};
  reg [34:0]  jm = {7'h07, 7'h20, 7'h10, 7'h08, 7'h07};
  reg [34:0]  jx = {7'h05, 7'h20, 7'h10, 7'h08, 7'h01};

  always #2.5 mclk = ~mclk;

  ssp_sequencer #(.TICK_CYCLES(4)) dut (
    .mclk(mclk), .resetn(resetn), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .run_cmd(run_cmd), .stop_req(stop_req),
    .din(din), .preset_index(preset_index), .seq_active(seq_active),
    .ramp_sel2(ramp_sel2), .dir_fwd(dir_fwd), .dir_rev(dir_rev),
    .seq_aux_output(seq_aux_output), .relay_out(relay_out),
    .opto_a_out(opto_a_out), .opto_b_out(opto_b_out),
    .normal_stop_req(normal_stop_req), .coast_stop_req(coast_stop_req),
    .sequence_end_fault(sequence_end_fault));

  ssp_drive_model partner (.mclk(mclk), .resetn(resetn),
    .user_stop(user_stop), .stop_req(stop_req),
    .end_req(normal_stop_req | coast_stop_req | sequence_end_fault));

  // ---------------------------------------------------------------
  // bus cycles and helpers
  // ---------------------------------------------------------------
  task chk(input [15:0] g, input [15:0] e);
    begin
      tests_run = tests_run + 1;
      if (g !== e) begin
        bad_count = bad_count + 1;
        $display("Error at %0t: got %h expected %h", $time, g, e);
      end
    end
  endtask
  task wr(input [4:0] a, input [15:0] v);
    begin
      @(posedge mclk);
      reg_addr <= a;
      reg_wdata <= v;
      reg_wr <= 1'b1;
      @(posedge mclk);
      reg_wr <= 1'b0;
    end
  endtask
  // data stand only in the cycle after the strobe, sampled 1 ns after the edge
  task rd(input [4:0] a);
    begin
      @(posedge mclk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge mclk);
      reg_rd <= 1'b0;
      #1 d = reg_rdata;
    end
  endtask
  // drive is stopped before any step word is touched
  task halt;
    begin
      @(posedge mclk);
      run_cmd <= 1'b0;
      repeat (3) @(posedge mclk);
    end
  endtask
  task go;
    begin
      @(posedge mclk);
      run_cmd <= 1'b1;
    end
  endtask
  // bounded wait; n equals lim when the pattern never showed
  task wait_obs(input [6:0] m, input [6:0] v, input integer lim);
    begin
      n = 0;
      while ((obs & m) !== v && n < lim) begin
        @(posedge mclk);
        #1 n = n + 1;
      end
    end
  endtask
  task results;
    begin
      $display("Comparisons %0d, mismatches %0d", tests_run, bad_count);
      if (bad_count == 0 && tests_run > 0)
        $display("Simulation passed");
      else
        $display("Simulation failed");
      $finish;
    end
  endtask

  // watchdog: a hang ends the run as a failure
  initial begin
    #400000;
    bad_count = bad_count + 1;
    results;
  end

  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  initial begin
    repeat (8) @(posedge mclk);
    resetn <= 1'b1;
    for (i = 0; i < 8; i = i + 1) begin
      rd(i[4:0]);
      chk(d, 16'h00F1);
      rd(i[4:0] + 5'h08);
      chk(d, 16'h012C);
    end
    wr(5'h1F, 16'h1234);
    rd(5'h1F);
    chk(d, 16'h0000);
    wr(5'h0F, 16'hFFFF);
    rd(5'h0F);
    chk(d, 16'h270F);
    wr(5'h12, 16'h0317);
    wr(5'h01, 16'h00FF);
    wr(5'h05, 16'h00FF);
    wr(5'h08, 16'h0002);
    go;
    repeat (10) @(posedge mclk);
    #1 chk(seq_active, 1'b0);
    wr(5'h10, 16'h0006);
    // condition codes, one or two rows each
    for (i = 0; i < 22; i = i + 1) begin
      r = rowv[175 - 8 * i -: 8];
      halt;
      wr(5'h00, {8'h00, 4'hF, r[7:4]});
      din <= {2'b00, r[2], r[3]};
      go;
      wait_obs(7'h47, 7'h41, 30);
      chk(n < 30, r[1]);
      if (r[0] && n < 30)
        chk(n >= 8, 1'b1);
    end
    // top digit: ramp set, aux state and direction; aux on relay and opto b, not opto a
    wr(5'h11, 16'h3C0F);
    for (i = 0; i < 12; i = i + 1) begin
      halt;
      wr(5'h00, {i[3:0], 12'h0FF});
      go;
      wait_obs(7'h40, 7'h40, 10);
      chk(n < 10, 1'b1);
      aux_e = (i % 6) >= 3;
      chk({ramp_sel2, seq_aux_output, dir_fwd, dir_rev, relay_out,
           opto_a_out, opto_b_out}, {i >= 6, aux_e, i % 3 == 0,
           i % 3 == 1, aux_e, 1'b0, aux_e});
    end
    // still running in step 0: status shows the run state and step
    rd(5'h14);
    chk(d, 16'h0008);
    // leaving sequence mode in mid-run drops back to idle
    wr(5'h10, 16'h0000);
    wait_obs(7'h40, 7'h00, 5);
    chk(n < 5, 1'b1);
    wr(5'h10, 16'h0006);
    // jump beats an immediate advance; ends and ignored destination
    // each row byte is jump code then destination
    for (i = 0; i < 5; i = i + 1) begin
      halt;
      din <= 4'h1;
      r = jv[39 - 8 * i -: 8];
      wr(5'h00, {4'h0, r[3:0], r[7:4], 4'h0});
      go;
      wait_obs(jm[34 - 7 * i -: 7], jx[34 - 7 * i -: 7], 20);
      chk(n < 20, 1'b1);
    end
    // step 7 advances on time and wraps back to step 0
    halt;
    wr(5'h00, 16'h0720);
    wr(5'h07, 16'h00F1);
    wr(5'h0F, 16'h0002);
    go;
    wait_obs(7'h47, 7'h47, 20);
    chk(n < 20, 1'b1);
    wait_obs(7'h47, 7'h40, 30);
    chk(n < 30, 1'b1);
    // stop in mid-run idles; no restart without a fresh start edge
    user_stop <= 1'b1;
    wait_obs(7'h40, 7'h00, 5);
    chk(n < 5, 1'b1);
    user_stop <= 1'b0;
    repeat (6) @(posedge mclk);
    #1 chk(seq_active, 1'b0);
    halt;
    go;
    wait_obs(7'h40, 7'h40, 10);
    chk(preset_index, 3'h0);
    // reset in mid-run: outputs clear, registers back to their defaults
    @(posedge mclk);
    resetn <= 1'b0;
    repeat (2) @(posedge mclk);
    #1 chk(obs, 7'h00);
    @(posedge mclk);
    resetn <= 1'b1;
    rd(5'h00);
    chk(d, 16'h00F1);
    rd(5'h10);
    chk(d, 16'h0000);
    // run still high at release is an edge, but the mode is not set
    repeat (4) @(posedge mclk);
    #1 chk(seq_active, 1'b0);
    results;
  end
endmodule // ssp_sequencer_tb
